// ### core/pip_mode_config_registers.v
// picture-in-picture system configuration and layout mode registers
`include "pip_cfg_defs.vh"

module pip_mode_config_registers #(
  parameter VIDEO_W = 16             // width of the video word passed through
) (
  input wire CLK_I,                  // line-locked clock, 100 MHz
  input wire RESETN_I,               // async reset, active low
  input wire [7:0] SUBADDR_I,        // register subaddress from serial slave
  input wire [15:0] WDATA_I,         // write data word
  input wire WR_I,                   // write strobe, one cycle
  input wire RD_I,                   // read strobe, one cycle
  output reg [15:0] RDATA_O,         // read data, held until next read
  output reg RVALID_O,               // read data valid, one cycle
  output reg CMD_PENDING_O,          // command pending flag
  input wire EXPERT_MODE_I,          // expert mode from layout engine
  input wire [VIDEO_W-1:0] VIDEO_I,  // video word in
  output reg [VIDEO_W-1:0] VIDEO_O,  // video word out, optionally delayed
  input wire WR_STROBE_REQ_I,        // internal memory write request
  input wire FETCH_STROBE_REQ_I,     // internal memory fetch request
  input wire IN_ENABLE_REQ_I,        // internal memory input enable
  input wire OUT_ENABLE_REQ_I,       // internal memory output enable
  input wire WRPTR_RESET_REQ_I,      // internal write pointer reset
  output wire MEM_WRITE_STROBE_O,    // memory write strobe pin
  output wire MEM_FETCH_STROBE_O,    // memory fetch strobe pin
  output wire MEM_INPUT_ENABLE_O,    // memory input enable pin
  output wire MEM_OUTPUT_ENABLE_O,   // memory output enable pin
  output wire MEM_WRPTR_RESET_O,     // memory write pointer reset pin
  output reg FIELD_MEM_CTRL_EN_O,    // field memory control enabled
  output reg SINGLE_CHIP_O,          // single-chip application
  output reg MAIN_ROLE_O,            // main-picture role
  output reg WIDESCREEN_O,           // 16:9 geometry
  output reg FAST_PIXEL_RATE_O,      // 16 MHz output pixel rate
  output reg WINDOW_525_O,           // inset window sized for 525 lines
  output reg [1:0] FIELD_MEM_KIND_O, // field memory kind code
  output reg MEM_KIND_RSVD_O,        // reserved memory kind selected
  output reg OUTPUT_DELAY_O,         // effective one-clock video delay
  output reg [3:0] LAYOUT_NUMBER_O,  // predefined layout number
  output reg FRAME_WRITE_BOTH_O,     // store both fields of each frame
  output reg DUAL_FIELD_BUFFER_O,    // two field buffers in use
  output reg MAIN_BACKGROUND_O,      // main picture shows background
  output reg UPSHIFT_ENABLE_O,       // vertical up-shift enabled
  output reg [5:0] UPSHIFT_LINES_O   // up-shift line count
);

  // staging copies, written by software
  reg [15:0] sys_stage_q;
  reg [15:0] sys_stage_d;
  reg [15:0] lay_stage_q;
  reg [15:0] lay_stage_d;

  // working copies, steer the block
  reg [15:0] sys_work_q;
  reg [15:0] lay_work_q;

  // command sequencing
  reg apply_q;    // command write seen, copy next edge
  reg done_q;     // copy made, outputs follow this edge
  reg pending_d;  // next pending flag

  // decoded settings, combinational
  reg kind_other;    // memory kind is the generic other
  reg main_role;     // working main-picture role
  reg expert_single; // expert mode with one buffer
  reg inset_side;    // inset role or single-chip
  reg [15:0] rdata_d;

  // video delay stage
  reg [VIDEO_W-1:0] video_hold_q;

  // address compare, used for writes and reads alike
  function hit;
    input [7:0] addr;
    input [7:0] want;
    begin
      hit = (addr == want);
    end
  endfunction

  // staging register writes
  // reserved bits (15:12 system, 15:14 layout) are kept as written; software keeps them zero
  always @* begin
    // default: staged words hold their value
    sys_stage_d = sys_stage_q;
    lay_stage_d = lay_stage_q;
    // system configuration write; outputs do not move yet
    if (WR_I && hit(SUBADDR_I, `SUB_SYSCFG)) begin
      sys_stage_d = WDATA_I;
    end
    // layout mode write; also waits for a command
    if (WR_I && hit(SUBADDR_I, `SUB_LAYOUT)) begin
      lay_stage_d = WDATA_I;
    end
  end

  // staging flops
  // read back as written, reserved bits included
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      // staged words clear to zero
      sys_stage_q <= `SYSCFG_RST;
      lay_stage_q <= `LAYOUT_RST;
    end else begin
      sys_stage_q <= sys_stage_d;
      lay_stage_q <= lay_stage_d;
    end
  end

  // command write detection
  // any write to the command subaddress triggers the copy
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      // no command in flight after reset
      apply_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      // one cycle to copy, one more for the decoded outputs
      apply_q <= WR_I & hit(SUBADDR_I, `SUB_CMD);
      // done marks the edge at which outputs show the copy
      done_q <= apply_q;
    end
  end

  // working copies
  // copy on command
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      // working words start cleared, every feature off
      sys_work_q <= `SYSCFG_RST;
      lay_work_q <= `LAYOUT_RST;
    end else if (apply_q) begin
      // both words copied together so settings never mix
      sys_work_q <= sys_stage_q;
      lay_work_q <= lay_stage_q;
    end
  end

  // pending flag next value
  // a new command with the pending bit written one in the clearing cycle keeps the flag set
  always @* begin
    // default: flag holds
    pending_d = CMD_PENDING_O;
    if (done_q) begin
      pending_d = 1'b0;
    end
    // set by a command with the pending bit written one
    if (WR_I && hit(SUBADDR_I, `SUB_CMD) && WDATA_I[`CMD_PEND_BIT]) begin
      pending_d = 1'b1;
    end
  end

  // pending flag flop
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      CMD_PENDING_O <= 1'b0;
    end else begin
      // flag also reads back through the command subaddress
      CMD_PENDING_O <= pending_d;
    end
  end

  // read mux
  // unmapped subaddresses read as zero
  always @* begin
    rdata_d = `RDATA_RST;
    if (hit(SUBADDR_I, `SUB_SYSCFG)) begin
      rdata_d = sys_stage_q;
    end else if (hit(SUBADDR_I, `SUB_LAYOUT)) begin
      // layout word, last value written
      rdata_d = lay_stage_q;
    end else if (hit(SUBADDR_I, `SUB_CMD)) begin
      // command register shows only the pending flag
      rdata_d[`CMD_PEND_BIT] = CMD_PENDING_O;
    end
  end

  // read answer flops, data held between reads
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RDATA_O <= `RDATA_RST;
      RVALID_O <= 1'b0;
    end else begin
      // valid is a single-cycle echo of the read strobe
      RVALID_O <= RD_I;
      if (RD_I) begin
        // data stands until the next read, so a slow master can take it late
        RDATA_O <= rdata_d;
      end
    end
  end

  // decode helpers from working copies
  always @* begin
    kind_other = (sys_work_q[`SC_KIND_HI:`SC_KIND_LO] == `KIND_OTHER);
    // role gates every main-only layout field
    main_role = sys_work_q[`SC_MAIN];
    // expert mode input is on this clock, no synchroniser needed
    expert_single = EXPERT_MODE_I & ~lay_work_q[`LM_DUAL];
    // single-chip parts write inset pictures too
    inset_side = ~main_role | sys_work_q[`SC_SINGLE];
  end

  // system configuration outputs
  // registered so every pin comes straight from a flop
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      // all features off until the first command
      FIELD_MEM_CTRL_EN_O <= 1'b0;
      SINGLE_CHIP_O <= 1'b0;
      MAIN_ROLE_O <= 1'b0;
      WIDESCREEN_O <= 1'b0;
      FAST_PIXEL_RATE_O <= 1'b0;
      WINDOW_525_O <= 1'b0;
      FIELD_MEM_KIND_O <= `KIND_FIRST;
      MEM_KIND_RSVD_O <= 1'b0;
      OUTPUT_DELAY_O <= 1'b0;
    end else begin
      FIELD_MEM_CTRL_EN_O <= sys_work_q[`SC_FMEM_EN];
      SINGLE_CHIP_O <= sys_work_q[`SC_SINGLE];
      MAIN_ROLE_O <= main_role;
      WIDESCREEN_O <= sys_work_q[`SC_WIDE];
      FAST_PIXEL_RATE_O <= sys_work_q[`SC_FAST];
      WINDOW_525_O <= sys_work_q[`SC_WINDOW_LINE_STANDARD];
      FIELD_MEM_KIND_O <= sys_work_q[`SC_KIND_HI:`SC_KIND_LO];
      // reserved code only flagged; nothing else reacts to it
      MEM_KIND_RSVD_O <= (sys_work_q[`SC_KIND_HI:`SC_KIND_LO] == `KIND_RSVD);
      OUTPUT_DELAY_O <= kind_other & sys_work_q[`SC_DELAY];
    end
  end

  // layout mode outputs
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      // layout zero, no shift, no background
      LAYOUT_NUMBER_O <= 4'h0;
      FRAME_WRITE_BOTH_O <= 1'b0;
      DUAL_FIELD_BUFFER_O <= 1'b0;
      MAIN_BACKGROUND_O <= 1'b0;
      UPSHIFT_ENABLE_O <= 1'b0;
      UPSHIFT_LINES_O <= 6'h00;
    end else begin
      LAYOUT_NUMBER_O <= lay_work_q[`LM_NUM_HI:`LM_NUM_LO];
      FRAME_WRITE_BOTH_O <= expert_single & inset_side & lay_work_q[`LM_FRAME];
      DUAL_FIELD_BUFFER_O <= EXPERT_MODE_I & lay_work_q[`LM_DUAL];
      MAIN_BACKGROUND_O <= main_role & EXPERT_MODE_I & lay_work_q[`LM_BGD];
      UPSHIFT_ENABLE_O <= main_role & lay_work_q[`LM_SHIFT];
      if (main_role && lay_work_q[`LM_SHIFT]) begin
        UPSHIFT_LINES_O <= lay_work_q[`LM_OFS_HI:`LM_OFS_LO];
      end else begin
        // forced to zero so a stale offset never leaks out
        UPSHIFT_LINES_O <= 6'h00;
      end
    end
  end

  // video path: one flop always, a second when delay is on
  // the delay follows the registered setting, so it flips with the outputs
  always @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      video_hold_q <= {VIDEO_W{1'b0}};
      VIDEO_O <= {VIDEO_W{1'b0}};
    end else begin
      // hold stage always runs, so turning the delay on loses no word
      video_hold_q <= VIDEO_I;
      if (OUTPUT_DELAY_O) begin
        // one extra clock for memories that need it
        VIDEO_O <= video_hold_q;
      end else begin
        // no delay: straight through one flop
        VIDEO_O <= VIDEO_I;
      end
    end
  end

  // strobe polarity stage; inversion only honoured for kind 11
  // write and fetch polarity
  // pointer reset polarity
  // pins come from flops inside the stage, one cycle after the request
  mem_strobe_polarity u_strobes (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .enable_i(FIELD_MEM_CTRL_EN_O),
    .inv_wr_fetch_i(kind_other & sys_work_q[`SC_WRPOL]),
    .inv_in_out_i(kind_other & sys_work_q[`SC_ENPOL]),
    .inv_wrptr_i(kind_other & sys_work_q[`SC_RSTPOL]),
    .write_strobe_i(WR_STROBE_REQ_I),
    .fetch_strobe_i(FETCH_STROBE_REQ_I),
    .input_enable_i(IN_ENABLE_REQ_I),
    .output_enable_i(OUT_ENABLE_REQ_I),
    .wrptr_reset_i(WRPTR_RESET_REQ_I),
    .write_strobe_o(MEM_WRITE_STROBE_O),
    .fetch_strobe_o(MEM_FETCH_STROBE_O),
    .input_enable_o(MEM_INPUT_ENABLE_O),
    .output_enable_o(MEM_OUTPUT_ENABLE_O),
    .wrptr_reset_o(MEM_WRPTR_RESET_O)
  );

endmodule // pip_mode_config_registers

// ### core/pip_cfg_defs.vh
// constants for the picture-in-picture mode configuration registers
`ifndef PIP_CFG_DEFS_VH
`define PIP_CFG_DEFS_VH

// serial subaddresses of the registers this block answers
`define SUB_CMD 8'h83
`define SUB_SYSCFG 8'h84
`define SUB_LAYOUT 8'h85

// reset values of staging and working copies and of the read data
`define SYSCFG_RST 16'h0000
`define LAYOUT_RST 16'h0000
`define RDATA_RST 16'h0000

// system configuration field positions
`define SC_FMEM_EN 0
`define SC_SINGLE 1
`define SC_MAIN 2
`define SC_WIDE 3
`define SC_FAST 4
`define SC_WINDOW_LINE_STANDARD 5
`define SC_KIND_LO 6
`define SC_KIND_HI 7
`define SC_DELAY 8
`define SC_WRPOL 9
`define SC_ENPOL 10
`define SC_RSTPOL 11

// field memory kind codes
`define KIND_FIRST 2'h0
`define KIND_SECOND 2'h1
`define KIND_RSVD 2'h2
`define KIND_OTHER 2'h3

// layout mode field positions
`define LM_NUM_LO 0
`define LM_NUM_HI 3
`define LM_FRAME 4
`define LM_DUAL 5
`define LM_BGD 6
`define LM_SHIFT 7
`define LM_OFS_LO 8
`define LM_OFS_HI 13

// command register: pending flag position
`define CMD_PEND_BIT 7

`endif

// ### core/mem_strobe_polarity.v
// registered polarity stage for the external field memory strobes
module mem_strobe_polarity (
  input wire clk_i,                 // line-locked clock
  input wire resetn_i,              // async reset, active low
  input wire enable_i,              // field memory control enabled
  input wire inv_wr_fetch_i,        // write/fetch strobes active low
  input wire inv_in_out_i,          // input/output enables active low
  input wire inv_wrptr_i,           // write pointer reset active low
  input wire write_strobe_i,        // internal write request, high active
  input wire fetch_strobe_i,        // internal fetch request, high active
  input wire input_enable_i,        // internal input enable, high active
  input wire output_enable_i,       // internal output enable, high active
  input wire wrptr_reset_i,         // internal pointer reset, high active
  output reg write_strobe_o,        // memory write strobe pin level
  output reg fetch_strobe_o,        // memory fetch strobe pin level
  output reg input_enable_o,        // memory input enable pin level
  output reg output_enable_o,       // memory output enable pin level
  output reg wrptr_reset_o          // memory write pointer reset pin level
);

  // pin level: request gated by enable, then flipped by polarity
  // a disabled controller parks every strobe at its idle level
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      write_strobe_o <= 1'b0;
      fetch_strobe_o <= 1'b0;
      input_enable_o <= 1'b0;
      output_enable_o <= 1'b0;
      wrptr_reset_o <= 1'b0;
    end else begin
      write_strobe_o <= (enable_i & write_strobe_i) ^ inv_wr_fetch_i;
      fetch_strobe_o <= (enable_i & fetch_strobe_i) ^ inv_wr_fetch_i;
      input_enable_o <= (enable_i & input_enable_i) ^ inv_in_out_i;
      output_enable_o <= (enable_i & output_enable_i) ^ inv_in_out_i;
      wrptr_reset_o <= (enable_i & wrptr_reset_i) ^ inv_wrptr_i;
    end
  end

endmodule // mem_strobe_polarity

// ### test/field_mem_model.sv
// behavioural external field memory driven by the strobe pins
module field_mem_model (
  input wire logic clk_i, // line-locked clock
  input wire logic wr_pin_i, // write strobe pin
  input wire logic rst_pin_i, // write pointer reset pin
  input wire logic wr_low_i, // write strobe active low
  input wire logic rst_low_i, // pointer reset active low
  output int wr_ptr_o // words written since reset
);
  initial wr_ptr_o = 0;
  always @(posedge clk_i) begin
    // pointer reset wins over a write in the same cycle
    if (rst_pin_i ^ rst_low_i) wr_ptr_o <= 0;
    else if (wr_pin_i ^ wr_low_i) wr_ptr_o <= wr_ptr_o + 1;
  end
endmodule // field_mem_model

// ### test/pip_cfg_assertions.sv
// port-level checks of the pip configuration registers
module pip_cfg_checker #(
  parameter int VIDEO_W = 16 // video word width
) (
  input wire logic CLK_I, // clock
  input wire logic RESETN_I, // reset, active low
  input wire logic [7:0] SUBADDR_I, // subaddress
  input wire logic [15:0] WDATA_I, // write data
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  input wire logic RVALID_O, // read valid
  input wire logic CMD_PENDING_O, // pending flag
  input wire logic [1:0] FIELD_MEM_KIND_O, // memory kind
  input wire logic MEM_KIND_RSVD_O, // reserved kind
  input wire logic OUTPUT_DELAY_O, // video delay
  input wire logic MAIN_ROLE_O, // main role
  input wire logic UPSHIFT_ENABLE_O, // up-shift on
  input wire logic [5:0] UPSHIFT_LINES_O, // up-shift lines
  input wire logic EXPERT_MODE_I, // expert mode
  input wire logic DUAL_FIELD_BUFFER_O, // two buffers
  input wire logic FIELD_MEM_CTRL_EN_O, // memory control on
  input wire logic WR_STROBE_REQ_I, // write request
  input wire logic MEM_WRITE_STROBE_O, // write strobe pin
  input wire logic [VIDEO_W-1:0] VIDEO_I, // video in
  input wire logic [VIDEO_W-1:0] VIDEO_O // video out
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  wire cmd_wr = WR_I && SUBADDR_I == 8'h83; // command write
  logic [4:0] hist_q; // recent command writes
  // quiet once no command landed lately, so pipelines settled
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) hist_q <= 5'h0;
    else hist_q <= {hist_q[3:0], cmd_wr};
  end
  wire quiet = hist_q == 5'h0; // settings steady
  sequence cmd_set; cmd_wr && WDATA_I[7]; endsequence
  sequence no_cmd2; !cmd_wr [*2]; endsequence
  a_valid_follows_read: assert property (RD_I |=> RVALID_O)
    else $error("read not answered");
  a_valid_only_read: assert property (!RD_I |=> !RVALID_O)
    else $error("stray read valid");
  a_pending_raised: assert property (cmd_set |=> CMD_PENDING_O)
    else $error("pending not set");
  a_pending_cleared: assert property (cmd_set ##1 no_cmd2 |=> !CMD_PENDING_O)
    else $error("pending not cleared");
  a_settings_hold: assert property (quiet |-> $stable({FIELD_MEM_KIND_O, MAIN_ROLE_O, UPSHIFT_LINES_O}))
    else $error("settings moved without command");
  a_kind_reserved_flag: assert property (MEM_KIND_RSVD_O == (FIELD_MEM_KIND_O == 2'h2))
    else $error("reserved kind flag wrong");
  a_delay_needs_other: assert property (OUTPUT_DELAY_O |-> FIELD_MEM_KIND_O == 2'h3)
    else $error("delay outside other kind");
  a_upshift_main_only: assert property (!MAIN_ROLE_O |-> !UPSHIFT_ENABLE_O && UPSHIFT_LINES_O == 6'h0)
    else $error("up-shift outside main role");
  a_dual_needs_expert: assert property (DUAL_FIELD_BUFFER_O |-> $past(EXPERT_MODE_I))
    else $error("dual buffer without expert");
  a_video_direct: assert property (quiet && !OUTPUT_DELAY_O |-> VIDEO_O == $past(VIDEO_I))
    else $error("video not one cycle");
  a_video_delayed: assert property (quiet && OUTPUT_DELAY_O |-> VIDEO_O == $past(VIDEO_I, 2))
    else $error("video not two cycles");
  a_strobe_plain: assert property (quiet && FIELD_MEM_KIND_O != 2'h3
    |-> MEM_WRITE_STROBE_O == $past(FIELD_MEM_CTRL_EN_O && WR_STROBE_REQ_I))
    else $error("write strobe level wrong");
endmodule // pip_cfg_checker

bind pip_mode_config_registers pip_cfg_checker #(.VIDEO_W(VIDEO_W)) pip_cfg_checker_inst (
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .SUBADDR_I(SUBADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RVALID_O(RVALID_O), .CMD_PENDING_O(CMD_PENDING_O), .FIELD_MEM_KIND_O(FIELD_MEM_KIND_O),
  .MEM_KIND_RSVD_O(MEM_KIND_RSVD_O), .OUTPUT_DELAY_O(OUTPUT_DELAY_O), .MAIN_ROLE_O(MAIN_ROLE_O),
  .UPSHIFT_ENABLE_O(UPSHIFT_ENABLE_O), .UPSHIFT_LINES_O(UPSHIFT_LINES_O), .EXPERT_MODE_I(EXPERT_MODE_I),
  .DUAL_FIELD_BUFFER_O(DUAL_FIELD_BUFFER_O), .FIELD_MEM_CTRL_EN_O(FIELD_MEM_CTRL_EN_O),
  .WR_STROBE_REQ_I(WR_STROBE_REQ_I), .MEM_WRITE_STROBE_O(MEM_WRITE_STROBE_O), .VIDEO_I(VIDEO_I), .VIDEO_O(VIDEO_O));

// ### test/pip_mode_config_registers_tb_top.sv
// self-checking bench for the pip configuration registers
module pip_mode_config_registers_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, wr_i, rd_i, expert; // bench-driven controls
  logic [7:0] sub; // subaddress
  logic [15:0] wdat, vid_in, st_s, st_l, wk_s, wk_l; // bus data, staged and working model
  logic [4:0] req; // write, fetch, in, out, pointer reset requests
  logic [31:0] seed; // xorshift state
  wire [15:0] rdata, vid_out; // read data, video out
  wire [23:0] dec; // decoded setting outputs
  wire [4:0] pins; // memory strobe pins
  wire rvalid, pend; // read valid, pending
  int err_count, checked, quiet_cnt; // counters
  int mem_ptr, exp_ptr; // memory model write pointer and its prediction
  logic [15:0] vq[$]; // recent video words, newest first
  pip_mode_config_registers pip_mode_config_registers_inst (
    .CLK_I(clk), .RESETN_I(rst_n), .SUBADDR_I(sub), .WDATA_I(wdat), .WR_I(wr_i), .RD_I(rd_i), .RDATA_O(rdata),
    .RVALID_O(rvalid), .CMD_PENDING_O(pend), .EXPERT_MODE_I(expert), .VIDEO_I(vid_in), .VIDEO_O(vid_out),
    .WR_STROBE_REQ_I(req[4]), .FETCH_STROBE_REQ_I(req[3]), .IN_ENABLE_REQ_I(req[2]), .OUT_ENABLE_REQ_I(req[1]),
    .WRPTR_RESET_REQ_I(req[0]), .MEM_WRITE_STROBE_O(pins[4]), .MEM_FETCH_STROBE_O(pins[3]),
    .MEM_INPUT_ENABLE_O(pins[2]), .MEM_OUTPUT_ENABLE_O(pins[1]), .MEM_WRPTR_RESET_O(pins[0]),
    .FIELD_MEM_CTRL_EN_O(dec[23]), .SINGLE_CHIP_O(dec[22]), .MAIN_ROLE_O(dec[21]), .WIDESCREEN_O(dec[20]),
    .FAST_PIXEL_RATE_O(dec[19]), .WINDOW_525_O(dec[18]), .FIELD_MEM_KIND_O(dec[17:16]), .MEM_KIND_RSVD_O(dec[15]),
    .OUTPUT_DELAY_O(dec[14]), .LAYOUT_NUMBER_O(dec[13:10]), .FRAME_WRITE_BOTH_O(dec[9]),
    .DUAL_FIELD_BUFFER_O(dec[8]), .MAIN_BACKGROUND_O(dec[7]), .UPSHIFT_ENABLE_O(dec[6]), .UPSHIFT_LINES_O(dec[5:0]));
  field_mem_model field_mem_model_inst (.clk_i(clk), .wr_pin_i(pins[4]), .rst_pin_i(pins[0]),
    .wr_low_i(wk_s[7:6] == 2'h3 && wk_s[9]), .rst_low_i(wk_s[7:6] == 2'h3 && wk_s[11]), .wr_ptr_o(mem_ptr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected decoded outputs from working words and expert level
  function automatic logic [23:0] expect_dec(input logic [15:0] s, input logic [15:0] l, input logic x);
    logic up;
    up = s[2] & l[7];
    return {s[0], s[1], s[2], s[3], s[4], s[5], s[7:6], s[7:6] == 2'h2, s[7:6] == 2'h3 && s[8], l[3:0],
      x & ~l[5] & (~s[2] | s[1]) & l[4], x & l[5], s[2] & x & l[6], up, up ? l[13:8] : 6'h0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    // one edge passes between back-to-back strobes
    @(negedge clk);
    sub = a;
    wdat = d;
    wr_i = 1'b1;
    @(negedge clk);
    wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] want);
    // one edge passes between back-to-back strobes
    @(negedge clk);
    sub = a;
    rd_i = 1'b1;
    @(negedge clk);
    rd_i = 1'b0;
    check(rvalid, 1'b1);
    check(rdata, want);
  endtask
  // command write copies staging into working, pending clears after
  task automatic apply(input logic [15:0] d);
    quiet_cnt = 0;
    wr(8'h83, d);
    wk_s = st_s;
    wk_l = st_l;
    @(negedge clk);
    check(pend, d[7]);
    @(negedge clk);
    check(pend, 1'b0);
    check(dec, expect_dec(wk_s, wk_l, expert));
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // random requests and video; pins and video checked once settled
  always @(negedge clk) begin
    logic k3;
    k3 = wk_s[7:6] == 2'h3;
    if (rst_n) begin
      vq.push_front(vid_in);
      if (quiet_cnt > 5) begin
        check(pins, ({5{wk_s[0]}} & req) ^ {{2{k3 & wk_s[9]}}, {2{k3 & wk_s[10]}}, k3 & wk_s[11]});
        check(vid_out, (k3 && wk_s[8]) ? vq[1] : vq[0]);
        check(mem_ptr, exp_ptr);
      end
      // pointer the memory should hold after the next edge
      exp_ptr = (wk_s[0] && req[0]) ? 0 : mem_ptr + int'(wk_s[0] && req[4]);
      if (vq.size() > 2) vq.pop_back();
      quiet_cnt++;
      req = rnd();
      vid_in = rnd();
    end
  end
  initial begin
    {rst_n, wr_i, rd_i, expert, sub, wdat, vid_in, req} = '0;
    {st_s, st_l, wk_s, wk_l} = '0;
    seed = 32'h49;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    check(dec, 24'h0);
    rd(8'h84, 16'h0000);
    rd(8'h85, 16'h0000);
    rd(8'h86, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      expert = rnd();
      st_s = {4'h0, rnd() & 12'hf3f} | (i[1:0] << 6);
      st_l = rnd() & 16'h3fff;
      wr(8'h84, st_s);
      wr(8'h85, st_l);
      rd(8'h84, st_s);
      rd(8'h85, st_l);
      check(dec, expect_dec(wk_s, wk_l, expert));
      apply({8'h0, i[0], 7'h0});
      repeat (8) @(negedge clk);
    end
    // pending flag reads back set, sampled at the same edge that clears it
    wr(8'h83, 16'h0080);
    rd(8'h83, 16'h0080);
    final_report;
  end
  initial begin
    #50000;
    err_count++;
    final_report;
  end
endmodule // pip_mode_config_registers_tb_top
